// ===== src/pfs_pkg.sv
/*
  Constants and carrier types for the port 1 pin-function select block.
  Assumes a 32-bit APB master and one shared clock and reset.
*/
package pfs_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_FUNC_SEL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_DIR      = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_LATCH    = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PULLUP   = 8'h0C;

  // Function-select field positions
  localparam int unsigned BIT_INT3_TRIG = 7;
  localparam int unsigned BIT_INT2      = 6;
  localparam int unsigned BIT_INT1      = 5;
  localparam int unsigned BIT_INT0      = 4;
  localparam int unsigned BIT_SER_TX    = 1;
  localparam int unsigned BIT_TMR_A_CLK = 0;
  localparam int unsigned PIN_ABSENT    = 3;

  // Reset values
  localparam logic [7:0] RST_FUNC_SEL = 8'h00;
  localparam logic [7:0] RST_DIR      = 8'h00;
  localparam logic [7:0] RST_LATCH    = 8'h00;
  localparam logic [7:0] RST_PULLUP   = 8'h00;
  localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;

  // Writable bits and bits that read as one
  localparam logic [7:0] WR_MASK_FUNC_SEL = 8'hF3;
  localparam logic [7:0] WR_MASK_PORT     = 8'hF7;
  localparam logic [7:0] RD_ONE_FUNC_SEL  = 8'h0C;
  localparam logic [7:0] RD_ONE_PORT      = 8'h08;

  // Port 1 pins that own an alternate role, and which of those drive
  localparam logic [7:0] ALT_PRESENT = 8'hF1;
  localparam logic [7:0] ALT_DRIVES  = 8'h01;

  // Idle level of an unselected interrupt or trigger line
  localparam logic ALT_IDLE = 1'b1;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } pfs_apb_req_t;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } pfs_apb_rsp_t;

endpackage : pfs_pkg

// ===== src/pfs_pin_cell.sv
/*
  One port 1 pin: chooses between general I/O and an alternate role.
  Assumes the pad level is synchronous to the system clock.
*/
`timescale 1ns/1ps
module pfs_pin_cell (
  input  wire logic alt_sel_in,
  input  wire logic alt_drives_in,
  input  wire logic alt_data_in,
  input  wire logic dir_in,
  input  wire logic latch_in,
  input  wire logic pullup_in,
  input  wire logic pad_in,
  output logic      pad_out,
  output logic      pad_oe_out,
  output logic      pullup_on_out,
  output logic      rd_bit_out,
  output logic      alt_level_out
);

  // RL13 alternate owns pin
  assign pad_oe_out    = alt_sel_in ? alt_drives_in : dir_in;
  // RL10 select picks latch or alternate data to drive
  assign pad_out       = alt_sel_in ? alt_data_in : latch_in;
  // RL12 pull-up on input
  assign pullup_on_out = pullup_in & ~pad_oe_out;
  // RL11 latch or live pin
  assign rd_bit_out    = dir_in ? latch_in : pad_in;
  assign alt_level_out = alt_sel_in ? pad_in : pfs_pkg::ALT_IDLE;

endmodule : pfs_pin_cell

// ===== src/pfs_port1_mux.sv
/*
  Port 1 pin-function select with its general I/O registers, on APB.
  Assumes a 125 MHz clock, synchronous pins and a port 2 block that
  supplies the general I/O drive of port 2 pin 2.
*/
// The register offsets and register access over APB are this design's own decisions.
// Contract
// RL1 - Select bit 7 gives port 1 pin 7 to interrupt line three and the timer V trigger.
// RL2 - Select bit 6 gives port 1 pin 6 to interrupt line two.
// RL3 - Select bit 5 gives port 1 pin 5 to interrupt line one.
// RL4 - Select bit 4 gives port 1 pin 4 to interrupt line zero.
// RL5 - Select bits 3 and 2 are reserved and always read as one.
// RL6 - Select bit 1 gives port 2 pin 2 to the serial transmit output.
// RL7 - Select bit 0 gives port 1 pin 0 to the timer A clock output.
// RL8 - After reset all pins are inputs and all alternate selections are clear.
// RL9 - Direction is chosen per bit and output values sit in a separate latch.
// RL10 - A general I/O pin drives when its direction bit is one, else it is an input.
// RL11 - Reading the latch gives stored bits for outputs and pin levels for inputs.
// RL12 - A pull-up bit works only while its pin is an input, one on and zero off.
// RL13 - With its select bit set the alternate role owns the pin and direction is ignored.
// RL14 - The six select bits read back as written and reserved bits ignore writes.
`timescale 1ns/1ps
module pfs_port1_mux (
  input  wire logic                  CLOCK_IN,
  input  wire logic                  SRST_IN,
  input  wire pfs_pkg::pfs_apb_req_t APB_REQ_IN,
  output pfs_pkg::pfs_apb_rsp_t      APB_RSP_OUT,
  input  wire logic [7:0]            P1_PIN_IN,
  output logic [7:0]                 P1_PIN_OUT,
  output logic [7:0]                 P1_PIN_OE_OUT,
  output logic [7:0]                 P1_PULLUP_OUT,
  input  wire logic                  TIMER_A_CLOCK_OUT_IN,
  input  wire logic                  SER_TX_DATA_IN,
  input  wire logic                  P2_GPIO_DATA_IN,
  input  wire logic                  P2_GPIO_DIR_IN,
  output logic                       P2_PIN2_OUT,
  output logic                       P2_PIN2_OE_OUT,
  output logic                       EXT_INT_LINE_THREE_OUT,
  output logic                       EXT_INT_LINE_TWO_OUT,
  output logic                       EXT_INT_LINE_ONE_OUT,
  output logic                       EXT_INT_LINE_ZERO_OUT,
  output logic                       TIMER_V_TRIGGER_INPUT_OUT
);

  // Register state
  logic [7:0]  func_sel_q;
  logic [7:0]  func_sel_d;
  logic [7:0]  dir_q;
  logic [7:0]  dir_d;
  logic [7:0]  latch_q;
  logic [7:0]  latch_d;
  logic [7:0]  pullup_q;
  logic [7:0]  pullup_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Bus decode
  logic        setup_ph;
  logic        access_ph;
  logic        aligned;
  logic        hit_sel;
  logic        hit_dir;
  logic        hit_latch;
  logic        hit_pu;
  logic        mapped;
  logic        wr_en;
  logic [7:0]  wbyte;
  logic [7:0]  rd_byte;
  logic [7:0]  pin_rd;
  logic [7:0]  alt_sel;
  logic [7:0]  alt_level;
  logic [7:0]  alt_data;
  logic [7:0]  rd_sel;
  logic [7:0]  rd_dir;
  logic [7:0]  rd_latch;
  logic [7:0]  rd_pu;
  logic        sel_tx;

  // Address match on an aligned word
  function automatic logic reg_hit(
    input logic [pfs_pkg::ADDR_W-1:0] addr,
    input logic [pfs_pkg::ADDR_W-1:0] off
  );
    reg_hit = (addr[pfs_pkg::ADDR_W-1:2] == off[pfs_pkg::ADDR_W-1:2]);
  endfunction : reg_hit

  // Phase decode
  assign setup_ph  = APB_REQ_IN.psel & ~APB_REQ_IN.penable;
  assign access_ph = APB_REQ_IN.psel & APB_REQ_IN.penable;
  // Register hits
  assign aligned   = (APB_REQ_IN.paddr[1:0] == 2'h0);
  assign hit_sel   = aligned & reg_hit(APB_REQ_IN.paddr, pfs_pkg::OFF_FUNC_SEL);
  assign hit_dir   = aligned & reg_hit(APB_REQ_IN.paddr, pfs_pkg::OFF_DIR);
  assign hit_latch = aligned & reg_hit(APB_REQ_IN.paddr, pfs_pkg::OFF_LATCH);
  assign hit_pu    = aligned & reg_hit(APB_REQ_IN.paddr, pfs_pkg::OFF_PULLUP);
  assign mapped    = hit_sel | hit_dir | hit_latch | hit_pu;
  assign wr_en     = access_ph & APB_REQ_IN.pwrite & mapped;
  assign wbyte     = APB_REQ_IN.pwdata[7:0];

  // RL14 implemented select bits only
  assign func_sel_d = (wr_en & hit_sel)
                    ? (wbyte & pfs_pkg::WR_MASK_FUNC_SEL) : func_sel_q;
  // RL9 per-bit direction
  assign dir_d      = (wr_en & hit_dir)
                    ? (wbyte & pfs_pkg::WR_MASK_PORT) : dir_q;
  // RL9 separate output latch
  assign latch_d    = (wr_en & hit_latch)
                    ? (wbyte & pfs_pkg::WR_MASK_PORT) : latch_q;
  // RL12 pull-up enables
  assign pullup_d   = (wr_en & hit_pu)
                    ? (wbyte & pfs_pkg::WR_MASK_PORT) : pullup_q;

  // RL5 reserved bits read one
  assign rd_sel   = func_sel_q | pfs_pkg::RD_ONE_FUNC_SEL;
  assign rd_dir   = dir_q;
  // RL11 mixed latch readback
  assign rd_latch = (pin_rd & pfs_pkg::WR_MASK_PORT) | pfs_pkg::RD_ONE_PORT;
  assign rd_pu    = pullup_q | pfs_pkg::RD_ONE_PORT;

  // Read byte selection
  assign rd_byte = hit_sel   ? rd_sel :
                   hit_dir   ? rd_dir :
                   hit_latch ? rd_latch :
                   hit_pu    ? rd_pu :
                   8'h00;

  // Read data captured in the setup cycle
  assign rdata_d = setup_ph ? {24'h00_0000, rd_byte} : rdata_q;

  // Zero-wait response
  assign APB_RSP_OUT.pready  = 1'b1;
  assign APB_RSP_OUT.pslverr = access_ph & ~mapped;
  assign APB_RSP_OUT.prdata  = rdata_q;

  // RL8 no alternates after reset
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      func_sel_q <= pfs_pkg::RST_FUNC_SEL;
    end else begin
      func_sel_q <= func_sel_d;
    end
  end

  // RL8 pins start as inputs
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      dir_q <= pfs_pkg::RST_DIR;
    end else begin
      dir_q <= dir_d;
    end
  end

  // Output latch
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      latch_q <= pfs_pkg::RST_LATCH;
    end else begin
      latch_q <= latch_d;
    end
  end

  // Pull-up enables
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      pullup_q <= pfs_pkg::RST_PULLUP;
    end else begin
      pullup_q <= pullup_d;
    end
  end

  // Read data hold
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      rdata_q <= pfs_pkg::RST_RDATA;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // RL13 alternate select per pin
  assign alt_sel  = func_sel_q & pfs_pkg::ALT_PRESENT;
  // RL7 timer A clock source
  assign alt_data = {7'h00, TIMER_A_CLOCK_OUT_IN};

  // Pin cells, pin 3 absent
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      if (gi == pfs_pkg::PIN_ABSENT) begin : g_none
        assign P1_PIN_OUT[gi]    = 1'b0;
        assign P1_PIN_OE_OUT[gi] = 1'b0;
        assign P1_PULLUP_OUT[gi] = 1'b0;
        assign pin_rd[gi]        = 1'b0;
        assign alt_level[gi]     = pfs_pkg::ALT_IDLE;
      end else begin : g_cell
        pfs_pin_cell u_cell (
          .alt_sel_in    (alt_sel[gi]),
          .alt_drives_in (pfs_pkg::ALT_DRIVES[gi]),
          .alt_data_in   (alt_data[gi]),
          .dir_in        (dir_q[gi]),
          .latch_in      (latch_q[gi]),
          .pullup_in     (pullup_q[gi]),
          .pad_in        (P1_PIN_IN[gi]),
          .pad_out       (P1_PIN_OUT[gi]),
          .pad_oe_out    (P1_PIN_OE_OUT[gi]),
          .pullup_on_out (P1_PULLUP_OUT[gi]),
          .rd_bit_out    (pin_rd[gi]),
          .alt_level_out (alt_level[gi])
        );
      end
    end
  endgenerate

  // RL1 line three and trigger
  assign EXT_INT_LINE_THREE_OUT    = alt_level[pfs_pkg::BIT_INT3_TRIG];
  assign TIMER_V_TRIGGER_INPUT_OUT = alt_level[pfs_pkg::BIT_INT3_TRIG];
  // RL2 line two
  assign EXT_INT_LINE_TWO_OUT      = alt_level[pfs_pkg::BIT_INT2];
  // RL3 line one
  assign EXT_INT_LINE_ONE_OUT      = alt_level[pfs_pkg::BIT_INT1];
  // RL4 line zero
  assign EXT_INT_LINE_ZERO_OUT     = alt_level[pfs_pkg::BIT_INT0];

  // RL6 serial transmit on port 2 pin 2
  assign sel_tx         = func_sel_q[pfs_pkg::BIT_SER_TX];
  assign P2_PIN2_OUT    = sel_tx ? SER_TX_DATA_IN : P2_GPIO_DATA_IN;
  assign P2_PIN2_OE_OUT = sel_tx | P2_GPIO_DIR_IN;

endmodule : pfs_port1_mux

// ===== verif/pfs_port1_mux_assertions.sv
/*
  Port-level checks for the port 1 pin-function select block.
  Assumes it is bound to every pfs_port1_mux instance.
*/
`timescale 1ns/1ps
module pfs_port1_mux_assertions (
  input wire logic                  CLOCK_IN,
  input wire logic                  SRST_IN,
  input wire pfs_pkg::pfs_apb_req_t APB_REQ_IN,
  input wire pfs_pkg::pfs_apb_rsp_t APB_RSP_OUT,
  input wire logic [7:0]            P1_PIN_IN,
  input wire logic [7:0]            P1_PIN_OE_OUT,
  input wire logic [7:0]            P1_PULLUP_OUT,
  input wire logic                  P2_GPIO_DATA_IN,
  input wire logic                  P2_PIN2_OUT,
  input wire logic                  P2_PIN2_OE_OUT,
  input wire logic                  EXT_INT_LINE_THREE_OUT,
  input wire logic                  EXT_INT_LINE_TWO_OUT,
  input wire logic                  EXT_INT_LINE_ONE_OUT,
  input wire logic                  EXT_INT_LINE_ZERO_OUT,
  input wire logic                  TIMER_V_TRIGGER_INPUT_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (SRST_IN);
  logic acc;
  assign acc = APB_REQ_IN.psel & APB_REQ_IN.penable;
  a_trig_mirror: assert property (TIMER_V_TRIGGER_INPUT_OUT == EXT_INT_LINE_THREE_OUT)
    else $error("trigger differs from line three");
  a_int3_owned: assert property (!EXT_INT_LINE_THREE_OUT |-> !P1_PIN_IN[7] && !P1_PIN_OE_OUT[7])
    else $error("line three low without pin ownership");
  a_int2_owned: assert property (!EXT_INT_LINE_TWO_OUT |-> !P1_PIN_IN[6] && !P1_PIN_OE_OUT[6])
    else $error("line two low without pin ownership");
  a_int1_owned: assert property (!EXT_INT_LINE_ONE_OUT |-> !P1_PIN_IN[5] && !P1_PIN_OE_OUT[5])
    else $error("line one low without pin ownership");
  a_int0_owned: assert property (!EXT_INT_LINE_ZERO_OUT |-> !P1_PIN_IN[4] && !P1_PIN_OE_OUT[4])
    else $error("line zero low without pin ownership");
  a_txd_owner: assert property (P2_PIN2_OUT != P2_GPIO_DATA_IN |-> P2_PIN2_OE_OUT)
    else $error("transmit data on undriven pin");
  a_pullup_input: assert property ((P1_PULLUP_OUT & P1_PIN_OE_OUT) == 8'h00)
    else $error("pull-up on a driven pin");
  a_reset_idle: assert property ($fell(SRST_IN) |-> P1_PIN_OE_OUT == 8'h00 && P1_PULLUP_OUT == 8'h00)
    else $error("pins not idle after reset");
  a_zero_wait: assert property (acc |-> APB_RSP_OUT.pready)
    else $error("access phase without ready");
  a_bad_addr: assert property (acc && APB_REQ_IN.paddr[1:0] != 2'b00 |-> APB_RSP_OUT.pslverr)
    else $error("misaligned access not refused");
  c_write: cover property (acc && APB_REQ_IN.pwrite);
  c_read: cover property (acc && !APB_REQ_IN.pwrite);
  c_alt_in: cover property (!EXT_INT_LINE_THREE_OUT);
endmodule : pfs_port1_mux_assertions

bind pfs_port1_mux pfs_port1_mux_assertions u_chk (.CLOCK_IN, .SRST_IN, .APB_REQ_IN,
  .APB_RSP_OUT, .P1_PIN_IN, .P1_PIN_OE_OUT, .P1_PULLUP_OUT, .P2_GPIO_DATA_IN, .P2_PIN2_OUT,
  .P2_PIN2_OE_OUT, .EXT_INT_LINE_THREE_OUT, .EXT_INT_LINE_TWO_OUT, .EXT_INT_LINE_ONE_OUT,
  .EXT_INT_LINE_ZERO_OUT, .TIMER_V_TRIGGER_INPUT_OUT);

// ===== verif/testbench.sv
/*
  Self-checking bench for the port 1 pin-function select block.
  Assumes the zero-wait APB slave and register map of pfs_pkg.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
  logic                  clk = 1'b0;
  logic                  srst = 1'b1;
  pfs_pkg::pfs_apb_req_t req = '0;
  pfs_pkg::pfs_apb_rsp_t rsp;
  logic [7:0]            pin_in = 8'h00, pin_out, pin_oe, pull;
  logic                  tmr = 1'b0, stx = 1'b0, p2d = 1'b0, p2r = 1'b0;
  logic                  p2o, p2oe, i3, i2, i1, i0, trg, err;
  logic [31:0]           rd;
  int                    err_total = 0;
  int                    compares = 0;
  always #4 clk = ~clk;
  pfs_port1_mux u_dut (.CLOCK_IN(clk), .SRST_IN(srst), .APB_REQ_IN(req), .APB_RSP_OUT(rsp),
    .P1_PIN_IN(pin_in), .P1_PIN_OUT(pin_out), .P1_PIN_OE_OUT(pin_oe), .P1_PULLUP_OUT(pull),
    .TIMER_A_CLOCK_OUT_IN(tmr), .SER_TX_DATA_IN(stx), .P2_GPIO_DATA_IN(p2d),
    .P2_GPIO_DIR_IN(p2r), .P2_PIN2_OUT(p2o), .P2_PIN2_OE_OUT(p2oe),
    .EXT_INT_LINE_THREE_OUT(i3), .EXT_INT_LINE_TWO_OUT(i2), .EXT_INT_LINE_ONE_OUT(i1),
    .EXT_INT_LINE_ZERO_OUT(i0), .TIMER_V_TRIGGER_INPUT_OUT(trg));
  task results;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] wd,
            output logic [31:0] d, output logic e);
    int n;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, {24'h00_0000, wd}};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (rsp.pready !== 1'b1 && n < 16);
    if (rsp.pready !== 1'b1) begin err_total++; results(); end
    d = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask : xfer
  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, rd, err);
  endtask : wr
  task chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    xfer(1'b0, a, 8'h00, rd, err);
    `CHK(nm, exp, rd)
  endtask : chk
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk(pfs_pkg::OFF_FUNC_SEL, 32'h0000_000C, "sel reset");
    `CHK("oe reset", 8'h00, pin_oe)
    `CHK("ints idle", 5'h1F, {i3, i2, i1, i0, trg})
    wr(pfs_pkg::OFF_FUNC_SEL, 8'h50);
    chk(pfs_pkg::OFF_FUNC_SEL, 32'h0000_005C, "sel 50");
    wr(pfs_pkg::OFF_FUNC_SEL, 8'hFF);
    chk(pfs_pkg::OFF_FUNC_SEL, 32'h0000_00FF, "sel FF");
    wr(pfs_pkg::OFF_DIR, 8'hFF);
    for (int b = 4; b < 8; b++) begin
      wr(pfs_pkg::OFF_FUNC_SEL, 8'h01 << b);
      @(posedge clk);
      `CHK("int route", ~(4'h1 << (b - 4)), {i3, i2, i1, i0})
      `CHK("trig route", (b == 7) ? 1'b0 : 1'b1, trg)
      `CHK("alt oe", 8'hF7 & ~(8'h01 << b), pin_oe)
      pin_in <= 8'hFF;
      @(posedge clk);
      `CHK("int follow", 5'h1F, {i3, i2, i1, i0, trg})
      pin_in <= 8'h00;
    end
    wr(pfs_pkg::OFF_DIR, 8'h00);
    wr(pfs_pkg::OFF_FUNC_SEL, 8'h01);
    tmr <= 1'b1;
    @(posedge clk);
    `CHK("tmr high", 2'b11, {pin_out[0], pin_oe[0]})
    tmr <= 1'b0;
    stx <= 1'b1;
    @(posedge clk);
    `CHK("tmr low", 2'b01, {pin_out[0], pin_oe[0]})
    wr(pfs_pkg::OFF_FUNC_SEL, 8'h02);
    @(posedge clk);
    `CHK("txd on", 2'b11, {p2o, p2oe})
    wr(pfs_pkg::OFF_FUNC_SEL, 8'h00);
    @(posedge clk);
    `CHK("txd off", 2'b00, {p2o, p2oe})
    p2d <= 1'b1;
    p2r <= 1'b1;
    stx <= 1'b0;
    @(posedge clk);
    `CHK("p2 gpio", 2'b11, {p2o, p2oe})
    wr(pfs_pkg::OFF_DIR, 8'h0F);
    wr(pfs_pkg::OFF_LATCH, 8'hA5);
    pin_in <= 8'h5A;
    @(posedge clk);
    `CHK("gpio oe", 8'h07, pin_oe)
    `CHK("gpio out", 8'h05, pin_out & pin_oe)
    chk(pfs_pkg::OFF_LATCH, 32'h0000_005D, "latch rd");
    wr(pfs_pkg::OFF_PULLUP, 8'hFF);
    @(posedge clk);
    `CHK("pullup", 8'hF0, pull)
    chk(pfs_pkg::OFF_PULLUP, 32'h0000_00FF, "pullup rd");
    chk(pfs_pkg::OFF_DIR, 32'h0000_0007, "dir rd");
    xfer(1'b0, 8'h10, 8'h00, rd, err);
    `CHK("unmapped", 33'h1_0000_0000, {err, rd})
    xfer(1'b1, 8'h05, 8'h00, rd, err);
    `CHK("misaligned", 1'b1, err)
    chk(pfs_pkg::OFF_DIR, 32'h0000_0007, "dir kept");
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    `CHK("oe reset2", 16'h0000, {pin_oe, pull})
    chk(pfs_pkg::OFF_DIR, 32'h0000_0000, "dir reset2");
    chk(pfs_pkg::OFF_FUNC_SEL, 32'h0000_000C, "sel reset2");
    results();
  end
endmodule : testbench
